// ==== dv/scs_host_model.sv ====
`timescale 1ns/1ps
module scs_host_model
(
   input wire logic ref_clk_in,
   input wire logic sdo_in,
   input wire logic sdo_oe_n_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out
);
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   end

   // half a link clock period of 160 ns
   task automatic half();
      repeat (4) @(negedge ref_clk_in);
   endtask

   // blocked gate bits, command, data; select stays low so frames can be chained
   task automatic xfer(input int ones, input logic [7:0] cmd, input logic [15:0] wdata,
         input int nbits, output logic [15:0] rdata);
      logic [23:0] sh;
      int i;
      rdata = 16'h0000;
      sh = {1'b0, cmd[6:0], wdata << (16 - nbits)};
      if (cs_n_out)
      begin
         @(negedge ref_clk_in);
         cs_n_out = 1'b0;
         half();
      end
      for (i = 0; i < ones + 8 + nbits; i++)
      begin
         sclk_out = 1'b0;
         sdi_out = (i < ones) ? 1'b1 : sh[23];
         if (i >= ones)
         begin
            sh = sh << 1;
         end
         half();
         sclk_out = 1'b1;
         half();
         // undriven sdo reads as unknown so it never passes a compare
         if (i >= ones + 8)
         begin
            rdata = {rdata[14:0], sdo_oe_n_in ? 1'bx : sdo_in};
         end
      end
   endtask

   task automatic end_frame();
      @(negedge ref_clk_in);
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
   endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import scs_pkg::*;
;
   logic ref_clk_in;
   logic arst_n_in;
   logic sclk, cs_n, sdi, sdo, sdo_oe_n;
   logic sync_n_in;
   logic [4:0] ev;
   logic [15:0] result_data_in;
   logic [15:0] error_flags_in;
   logic [15:0] reg_rd_data_in;
   logic drdy_out;
   logic reg_rd_req_out;
   logic [5:0] reg_addr_out;
   logic reg_wr_strobe_out;
   scs_reg_xfer_s reg_wr_out;
   scs_reg_xfer_s wr_seen;
   logic [5:0] rd_addr;
   logic [7:0] command_byte_out;
   logic [7:0] status_out;
   logic [15:0] rd;
   int err_total = 0;
   int samples_checked = 0;
   int wr_cnt = 0;
   int cyc = 0;
   int i;

   scs_core scs_core_inst (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .sclk_in(sclk),
      .cs_n_in(cs_n),
      .sdi_in(sdi),
      .sync_n_in(sync_n_in),
      .sdo_out(sdo),
      .sdo_oe_n_out(sdo_oe_n),
      .drdy_out(drdy_out),
      .result_valid_in(ev[0]),
      .result_data_in(result_data_in),
      .cal_coef_write_in(ev[1]),
      .idle_standby_in(ev[2]),
      .cal_start_in(ev[3]),
      .conv_start_in(ev[4]),
      .error_flags_in(error_flags_in),
      .reg_rd_data_in(reg_rd_data_in),
      .reg_rd_req_out(reg_rd_req_out),
      .reg_addr_out(reg_addr_out),
      .reg_wr_strobe_out(reg_wr_strobe_out),
      .reg_wr_out(reg_wr_out),
      .command_byte_out(command_byte_out),
      .status_out(status_out)
   );

   scs_host_model scs_host_model_inst (
      .ref_clk_in(ref_clk_in),
      .sdo_in(sdo),
      .sdo_oe_n_in(sdo_oe_n),
      .sclk_out(sclk),
      .cs_n_out(cs_n),
      .sdi_out(sdi)
   );

   initial
   begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // sampled on the falling edge, clear of the launching edge
   always @(negedge ref_clk_in)
   begin
      cyc++;
      if (reg_wr_strobe_out === 1'b1)
      begin
         wr_cnt++;
         wr_seen = reg_wr_out;
      end
      if (reg_rd_req_out === 1'b1)
      begin
         rd_addr = reg_addr_out;
      end
      // a hung handshake ends the run here
      if (cyc == 20000)
      begin
         err_total++;
         end_sim();
      end
   end

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask

   task automatic pulse(input int k);
      @(negedge ref_clk_in);
      ev[k] = 1'b1;
      @(negedge ref_clk_in);
      ev = 5'h00;
   endtask

   task automatic post(input logic [15:0] w);
      result_data_in = w;
      pulse(0);
      wait_clk(6);
   endtask

   initial
   begin
      arst_n_in = 1'b0;
      sync_n_in = 1'b1;
      ev = 5'h00;
      result_data_in = 16'h0000;
      error_flags_in = 16'h0000;
      reg_rd_data_in = 16'h3c96;
      wait_clk(10);
      arst_n_in = 1'b1;
      wait_clk(5);
      check(24'(status_out), 24'(SCS_STATUS_RESET));
      check(24'(command_byte_out), 24'(SCS_CMD_RESET));
      check(24'(drdy_out), 24'h00_0000);
      // status read behind three blocked gate bits
      scs_host_model_inst.xfer(3, 8'h40, 16'h0000, 8, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(rd), 24'h00_0010);
      check(24'(command_byte_out), 24'h00_0040);
      error_flags_in = 16'h0100;
      wait_clk(3);
      check(24'(status_out[6]), 24'h00_0001);
      error_flags_in = 16'h0000;
      wait_clk(3);
      check(24'(status_out[6]), 24'h00_0000);
      result_data_in = 16'ha5c3;
      pulse(0);
      wait_clk(1);
      check(24'(drdy_out), 24'h00_0001);
      wait_clk(2);
      check(24'(drdy_out), 24'h00_0001);
      wait_clk(1);
      check(24'(drdy_out), 24'h00_0000);
      check(24'(status_out[7]), 24'h00_0000);
      scs_host_model_inst.xfer(0, 8'h42, 16'h0000, 16, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(rd), 24'h00_a5c3);
      check(24'(drdy_out), 24'h00_0001);
      // chained frames with no deselect in between
      scs_host_model_inst.xfer(0, 8'h05, 16'h1234, 16, rd);
      scs_host_model_inst.xfer(2, 8'h47, 16'h0000, 16, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(wr_cnt), 24'h00_0001);
      check(24'(wr_seen), 24'({6'h05, 16'h1234}));
      check(24'(rd), 24'h00_3c96);
      check(24'(rd_addr), 24'h00_0007);
      scs_host_model_inst.xfer(0, 8'h00, 16'h00ff, 8, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(wr_cnt), 24'h00_0001);
      // new result lands in the middle of a data register read
      post(16'h0f0f);
      result_data_in = 16'hf0f0;
      fork
         scs_host_model_inst.xfer(0, 8'h42, 16'h0000, 16, rd);
         begin
            wait_clk(100);
            pulse(0);
         end
      join
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(rd), 24'h00_0f0f);
      check(24'(drdy_out), 24'h00_0001);
      scs_host_model_inst.xfer(0, 8'h42, 16'h0000, 16, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(rd), 24'h00_0f0f);
      for (i = 2; i < 5; i++)
      begin
         post(16'h1111);
         check(24'(drdy_out), 24'h00_0000);
         pulse(i);
         wait_clk(2);
         check(24'(drdy_out), 24'h00_0001);
      end
      pulse(1);
      wait_clk(2);
      check(24'(drdy_out), 24'h00_0000);
      post(16'h2222);
      // a read of another register leaves the pending flag alone
      scs_host_model_inst.xfer(0, 8'h47, 16'h0000, 16, rd);
      scs_host_model_inst.end_frame();
      wait_clk(8);
      check(24'(rd), 24'h00_3c96);
      check(24'(drdy_out), 24'h00_0000);
      sync_n_in = 1'b0;
      wait_clk(8);
      check(24'(drdy_out), 24'h00_0001);
      sync_n_in = 1'b1;
      wait_clk(8);
      end_sim();
   end
endmodule

// ==== src/scs_core.sv ====
// Functional notes
// - gate bit high: stay on first position
// - after low gate, shift seven command bits
// - command bit 6 picks write or read
// - low six command bits select register
// - new result clears pending flag, pin low
// - ready pin high when flag is one
// - calibration coefficient writes clear pending flag
// - data read sets flag; coefficient reads don't
// - idle, calibration or conversion start set flag
// - sync low sets flag if data unread
// - flag set four clocks before result write
// - result write dropped during data read
// - error summary follows any error flag
// - status at address zero, resets 0x10
// - command register unaddressed, resets 0x10
`timescale 1ns/1ps
module scs_core
   import scs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   input wire logic sync_n_in,
   output logic sdo_out,
   output logic sdo_oe_n_out,
   output logic drdy_out,
   input wire logic result_valid_in,
   input wire logic [15:0] result_data_in,
   input wire logic cal_coef_write_in,
   input wire logic idle_standby_in,
   input wire logic cal_start_in,
   input wire logic conv_start_in,
   input wire logic [15:0] error_flags_in,
   input wire logic [15:0] reg_rd_data_in,
   output logic reg_rd_req_out,
   output logic [5:0] reg_addr_out,
   output logic reg_wr_strobe_out,
   output scs_reg_xfer_s reg_wr_out,
   output logic [7:0] command_byte_out,
   output logic [7:0] status_out
);
   scs_pins_s pins_raw;
   scs_pins_s pins;
   assign pins_raw = '{sclk: sclk_in, cs_n: cs_n_in, din: sdi_in, sync_n: sync_n_in};

   scs_sync3 u_sync (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .pins_in(pins_raw),
      .pins_out(pins)
   );

   function automatic logic [4:0] data_len(input logic [5:0] addr);
      data_len = (addr == SCS_STATUS_ADDR) ? SCS_STATUS_BITS : SCS_WORD_BITS;
   endfunction

   // serial engine state
   scs_state_e state, next_state;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [15:0] shift, next_shift;
   logic [7:0] cmd_reg, next_cmd_reg;
   logic sdo, next_sdo;
   logic sclk_d, sync_d;
   logic wr_strobe, next_wr_strobe;
   scs_reg_xfer_s wr_xfer, next_wr_xfer;
   logic sclk_rise, sclk_fall, sync_fall, cmd_done;
   logic [5:0] cmd_addr;

   // status state
   logic result_pending_n, next_result_pending_n;
   logic por, next_por;
   logic unread, next_unread;
   logic pre_active, next_pre_active;
   logic [2:0] pre_cnt, next_pre_cnt;
   logic [15:0] pend_data, next_pend_data;
   logic [15:0] data_reg, next_data_reg;
   logic commit_evt, set_evt, clear_evt, data_read_evt, status_read_evt, rd_in_progress;
   logic err_summary;
   logic [7:0] status_word;

   assign sclk_rise = pins.sclk && !sclk_d;
   assign sclk_fall = !pins.sclk && sclk_d;
   assign sync_fall = !pins.sync_n && sync_d;
   assign cmd_done = (state == ST_CMD) && sclk_rise && (bit_cnt[2:0] == SCS_CMD_LAST);
   assign cmd_addr = cmd_reg[5:0];
   assign data_read_evt = (state == ST_FETCH) && (cmd_addr == SCS_DATA_ADDR);
   assign status_read_evt = (state == ST_FETCH) && (cmd_addr == SCS_STATUS_ADDR);
   // coefficient reads leave the flag alone
   assign rd_in_progress = ((state == ST_FETCH) || (state == ST_RD))
                           && (cmd_addr == SCS_DATA_ADDR);

   always_comb
   begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_cmd_reg = cmd_reg;
      next_sdo = sdo;
      next_wr_strobe = 1'b0;
      next_wr_xfer = wr_xfer;
      // a raised select abandons any half-finished frame
      if (pins.cs_n)
      begin
         next_state = ST_GATE;
         next_bit_cnt = '0;
      end
      else
      begin
         case (state)
            ST_GATE:
            begin
               // a high gate bit parks the pointer here
               if (sclk_rise && !pins.din)
               begin
                  next_state = ST_CMD;
                  next_bit_cnt = '0;
               end
            end
            ST_CMD:
            begin
               if (sclk_rise)
               begin
                  next_shift = {shift[14:0], pins.din};
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (cmd_done)
                  begin
                     next_cmd_reg = {1'b0, shift[5:0], pins.din};
                     next_bit_cnt = '0;
                     next_state = shift[5] ? ST_FETCH : ST_WR;
                  end
               end
            end
            ST_WR:
            begin
               if (sclk_rise)
               begin
                  next_shift = {shift[14:0], pins.din};
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == data_len(cmd_addr) - 5'h01)
                  begin
                     next_wr_xfer.addr = cmd_addr;
                     next_wr_xfer.data = {shift[14:0], pins.din};
                     // status is read-only; such writes are swallowed
                     next_wr_strobe = (cmd_addr != SCS_STATUS_ADDR);
                     // pointer back at the gate position for a chained frame
                     next_bit_cnt = '0;
                     next_state = ST_GATE;
                  end
               end
            end
            ST_FETCH:
            begin
               // one clock, well inside the half sclk period
               if (cmd_addr == SCS_STATUS_ADDR)
               begin
                  next_shift = {status_word, 8'h00};
               end
               else if (cmd_addr == SCS_DATA_ADDR)
               begin
                  next_shift = data_reg;
               end
               else
               begin
                  next_shift = reg_rd_data_in;
               end
               next_state = ST_RD;
            end
            ST_RD:
            begin
               if (sclk_fall)
               begin
                  next_sdo = shift[15];
                  next_shift = {shift[14:0], 1'b0};
               end
               if (sclk_rise)
               begin
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == data_len(cmd_addr) - 5'h01)
                  begin
                     next_bit_cnt = '0;
                     next_state = ST_GATE;
                  end
               end
            end
            default:
            begin
               next_state = ST_GATE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state <= ST_GATE;
         bit_cnt <= '0;
         shift <= '0;
         cmd_reg <= SCS_CMD_RESET;
         sdo <= 1'b0;
         sclk_d <= 1'b1;
         sync_d <= 1'b1;
         wr_strobe <= 1'b0;
         wr_xfer <= '0;
      end
      else
      begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         cmd_reg <= next_cmd_reg;
         sdo <= next_sdo;
         sclk_d <= pins.sclk;
         sync_d <= pins.sync_n;
         wr_strobe <= next_wr_strobe;
         wr_xfer <= next_wr_xfer;
      end
   end

   assign err_summary = |error_flags_in;
   assign status_word = {result_pending_n, err_summary, 1'b0, por, 4'h0};
   assign commit_evt = pre_active && (pre_cnt == 3'h0);
   // set events win over a clearing event in the same clock
   assign set_evt = result_valid_in || idle_standby_in || cal_start_in || conv_start_in
                    || data_read_evt || (sync_fall && unread);
   assign clear_evt = (commit_evt && !rd_in_progress) || cal_coef_write_in;

   always_comb
   begin
      next_pre_active = pre_active;
      next_pre_cnt = pre_cnt;
      next_pend_data = pend_data;
      next_data_reg = data_reg;
      next_unread = unread;
      next_por = por && !status_read_evt;
      if (pre_active)
      begin
         next_pre_cnt = pre_cnt - 3'h1;
         if (commit_evt)
         begin
            next_pre_active = 1'b0;
            // a live data read keeps the old word whole; this result is lost
            if (!rd_in_progress)
            begin
               next_data_reg = pend_data;
               next_unread = 1'b1;
            end
         end
      end
      if (result_valid_in)
      begin
         next_pend_data = result_data_in;
         next_pre_active = 1'b1;
         next_pre_cnt = SCS_PRE_WRITE_CNT;
      end
      if (data_read_evt)
      begin
         next_unread = 1'b0;
      end
      next_result_pending_n = result_pending_n;
      if (clear_evt)
      begin
         next_result_pending_n = 1'b0;
      end
      if (set_evt)
      begin
         next_result_pending_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         result_pending_n <= SCS_STATUS_RESET[SCS_STAT_PEND_BIT];
         por <= SCS_STATUS_RESET[SCS_STAT_POR_BIT];
         unread <= 1'b0;
         pre_active <= 1'b0;
         pre_cnt <= '0;
         pend_data <= '0;
         data_reg <= '0;
      end
      else
      begin
         result_pending_n <= next_result_pending_n;
         por <= next_por;
         unread <= next_unread;
         pre_active <= next_pre_active;
         pre_cnt <= next_pre_cnt;
         pend_data <= next_pend_data;
         data_reg <= next_data_reg;
      end
   end

   assign sdo_out = sdo;
   assign sdo_oe_n_out = (state != ST_RD);
   assign drdy_out = result_pending_n;
   assign reg_rd_req_out = (state == ST_FETCH) && (cmd_addr != SCS_STATUS_ADDR)
                           && (cmd_addr != SCS_DATA_ADDR);
   assign reg_addr_out = cmd_addr;
   assign reg_wr_strobe_out = wr_strobe;
   assign reg_wr_out = wr_xfer;
   assign command_byte_out = cmd_reg;
   assign status_out = status_word;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_gate_rise(logic bit_val);
      (state == ST_GATE) && !pins.cs_n && sclk_rise && (pins.din == bit_val);
   endsequence
   sequence s_result_wait;
      result_valid_in ##1 (!result_valid_in)[*3];
   endsequence

   property p_gate_hold;
      s_gate_rise(1'b1) |=> (state == ST_GATE) && (bit_cnt == 5'h00);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gate high moved pointer");
   property p_gate_open;
      s_gate_rise(1'b0) |=> (state == ST_CMD) ##0 (bit_cnt == 5'h00);
   endproperty
   a_gate_open: assert property (p_gate_open) else $error("gate low ignored");
   property p_direction;
      cmd_done && !pins.cs_n |=> (state == ($past(shift[5]) ? ST_FETCH : ST_WR));
   endproperty
   a_direction: assert property (p_direction) else $error("wrong direction");
   property p_address;
      cmd_done && !pins.cs_n |=> reg_addr_out == $past({shift[4:0], pins.din});
   endproperty
   a_address: assert property (p_address) else $error("wrong register select");
   property p_result_write;
      commit_evt && !rd_in_progress && !set_evt |=> !drdy_out && (data_reg == $past(pend_data));
   endproperty
   a_result_write: assert property (p_result_write) else $error("result not posted");
   property p_pin_high;
      $rose(result_pending_n) |-> drdy_out && status_out[SCS_STAT_PEND_BIT];
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("ready pin not high");
   property p_cal_clear;
      cal_coef_write_in && !set_evt |=> !result_pending_n;
   endproperty
   a_cal_clear: assert property (p_cal_clear) else $error("cal write kept flag");
   property p_data_read;
      data_read_evt |=> result_pending_n ##1 !unread;
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read kept flag low");
   property p_busy_set;
      idle_standby_in || cal_start_in || conv_start_in |=> result_pending_n;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("start did not set flag");
   property p_sync_set;
      sync_fall && unread |=> result_pending_n;
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("sync did not set flag");
   property p_pre_write;
      s_result_wait |=> commit_evt && $past(result_pending_n, 3);
   endproperty
   a_pre_write: assert property (p_pre_write) else $error("result write off timing");
   property p_drop;
      commit_evt && rd_in_progress |=> $stable(data_reg);
   endproperty
   a_drop: assert property (p_drop) else $error("result mixed into read");
   property p_err;
      status_out[6] == (error_flags_in != 16'h0000);
   endproperty
   a_err: assert property (p_err) else $error("error summary wrong");
   property p_back_to_wait;
      (state == ST_WR) && !pins.cs_n && sclk_rise && (bit_cnt == data_len(cmd_addr) - 5'h01)
      |=> (state == ST_GATE) ##1 (state == ST_GATE);
   endproperty
   a_back_to_wait: assert property (p_back_to_wait) else $error("no return to wait");
endmodule

// ==== src/scs_pkg.sv ====
package scs_pkg;

   localparam logic [5:0] SCS_STATUS_ADDR = 6'h00;
   localparam logic [5:0] SCS_DATA_ADDR = 6'h02;
   localparam logic [7:0] SCS_CMD_RESET = 8'h10;
   localparam logic [7:0] SCS_STATUS_RESET = 8'h10;
   localparam int SCS_CMD_DIR_BIT = 6;
   localparam int SCS_STAT_PEND_BIT = 7;
   localparam int SCS_STAT_POR_BIT = 4;
   localparam logic [4:0] SCS_STATUS_BITS = 5'h08;
   localparam logic [4:0] SCS_WORD_BITS = 5'h10;
   localparam logic [2:0] SCS_CMD_LAST = 3'h6;
   localparam int SCS_PRE_WRITE_MCLK = 4;
   localparam logic [2:0] SCS_PRE_WRITE_CNT = 3'(SCS_PRE_WRITE_MCLK - 1);

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
      logic sync_n;
   } scs_pins_s;

   localparam scs_pins_s SCS_PINS_IDLE = 4'hd;

   typedef enum logic [2:0] {
      ST_GATE,
      ST_CMD,
      ST_WR,
      ST_FETCH,
      ST_RD
   } scs_state_e;

   typedef struct packed {
      logic [5:0] addr;
      logic [15:0] data;
   } scs_reg_xfer_s;

endpackage

// ==== src/scs_sync3.sv ====
`timescale 1ns/1ps
module scs_sync3
   import scs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire scs_pins_s pins_in,
   output scs_pins_s pins_out
);
   scs_pins_s ff1;
   scs_pins_s ff2;
   scs_pins_s ff3;
   scs_pins_s stable;
   scs_pins_s next_stable;
   scs_pins_s agree;

   // a bit changes only once the second and third stages agree
   always_comb
   begin
      agree = ff2 ~^ ff3;
      next_stable = (stable & ~agree) | (ff3 & agree);
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ff1 <= SCS_PINS_IDLE;
         ff2 <= SCS_PINS_IDLE;
         ff3 <= SCS_PINS_IDLE;
         stable <= SCS_PINS_IDLE;
      end
      else
      begin
         ff1 <= pins_in;
         ff2 <= ff1;
         ff3 <= ff2;
         stable <= next_stable;
      end
   end

   assign pins_out = stable;
endmodule
